// File: fast_guard_params.svh
// Register map, field positions and reset values of the fast guard
`ifndef FAST_GUARD_PARAMS_SVH
`define FAST_GUARD_PARAMS_SVH

// Word offsets on the register bus (byte addresses)
`define FG_ADDR_CTRL      8'h00
`define FG_ADDR_SAT_BLANK 8'h04
`define FG_ADDR_OCP_BLANK 8'h08
`define FG_ADDR_LIVE      8'h0C
`define FG_ADDR_EVT_STAT  8'h10
`define FG_ADDR_EVT_CLR   8'h14
`define FG_ADDR_EVT_EN    8'h18

// Control register fields
`define FG_CTRL_CLAMP_BIT   0
`define FG_CTRL_THR_LSB     1
`define FG_CTRL_THR_MSB     2
`define FG_CTRL_REACT_BIT   3
`define FG_CTRL_SAT_EN_BIT  4
`define FG_CTRL_OCP_EN_BIT  5
`define FG_CTRL_MSB         5

// Live status register fields
`define FG_LIVE_SAT_BIT   0
`define FG_LIVE_OCP1_BIT  1
`define FG_LIVE_OCP2_BIT  2
`define FG_LIVE_ENV_BIT   3
`define FG_LIVE_HALT_BIT  4
`define FG_LIVE_PULL_BIT  5

// Event register fields
`define FG_EVT_SAT_BIT    0
`define FG_EVT_OCP_BIT    1
`define FG_EVT_EN_BIT     2
`define FG_EVT_CHK_BIT    3
`define FG_EVT_W          4

// Reset values
`define FG_CTRL_RST       6'h30
`define FG_SAT_BLANK_RST  16'h0064
`define FG_OCP_BLANK_RST  16'h0032
`define FG_EVT_EN_RST     4'h0

// Synchroniser length
`define FG_SYNC_IN_W      3

`endif

// File: fast_guard_pkg.sv
// Types shared by the fast guard block
package fast_guard_pkg;
  // Guard state, one-hot
  typedef enum logic [1:0] {
    ST_RUN  = 2'h1,
    ST_HALT = 2'h2
  } guard_state_t;
endpackage

// File: fast_guard.sv
// Fast protection logic: saturation, overcurrent, external enable
//
// The Wishbone interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "fast_guard_params.svh"

module fast_guard #(
  parameter int CNT_W = 16  // Blanking counter width
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Classic Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Command side, same clock
  input  wire logic        pwm_on_cmd,
  input  wire logic        two_level_turnoff,
  input  wire logic        hard_off_start,
  // Analog comparator outputs, asynchronous
  input  wire logic        saturation_comp_raw,
  input  wire logic        overcurrent_shutdown_raw,
  input  wire logic        overcurrent_check_raw,
  input  wire logic        external_enable_valid_raw,
  // Analog controls
  output logic             saturation_sense_pulldown,
  output logic             saturation_sense_clamp,
  output logic [1:0]       saturation_threshold_select,
  // Turn-off requests and fault line
  output logic             safe_turnoff_req,
  output logic             regular_turnoff_req,
  output logic             driver_disabled,
  output logic             fast_fault_output_n,
  output logic             irq
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------

  // Raw inputs gathered for a common three-stage chain
  wire  [3:0] raw_in;
  // Sync stages; stage one feeds stage two only
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] sync3_q;
  // Accepted level per input
  logic [3:0] filt_q;
  // Stage agreement mask
  wire  [3:0] agree;

  assign raw_in = {external_enable_valid_raw, overcurrent_check_raw,
                   overcurrent_shutdown_raw, saturation_comp_raw};
  assign agree  = ~(sync2_q ^ sync3_q);

  // Three flops, then take a change once stages two and three agree
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      sync3_q <= 4'h0;
      filt_q  <= 4'h0;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q  <= (agree & sync3_q) | (~agree & filt_q);
    end
  end

  // Filtered comparator levels
  wire sat_cmp  = filt_q[0];
  wire ocp1_cmp = filt_q[1];
  wire ocp2_cmp = filt_q[2];
  wire env_cmp  = filt_q[3];

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------

  // Control bits
  logic [`FG_CTRL_MSB:0] ctrl_q;
  // Saturation blanking time in clock cycles
  logic [CNT_W-1:0]      saturation_blanking_time_reg_q;
  // Overcurrent blanking time in clock cycles
  logic [CNT_W-1:0]      overcurrent_blanking_time_reg_q;
  // Sticky events and their enables
  logic [`FG_EVT_W-1:0]  evt_q;
  logic [`FG_EVT_W-1:0]  evt_d;
  logic [`FG_EVT_W-1:0]  evt_en_q;
  // Bus handshake
  logic                  ack_q;
  logic [31:0]           rdat_q;

  // Address match helper, used by every decode
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  // Byte-lane merge for 16-bit registers
  function automatic logic [CNT_W-1:0] merge16(
      input logic [CNT_W-1:0] old_v,
      input logic [31:0]      new_v,
      input logic [3:0]       sel);
    logic [15:0] m;
    m = 16'h0000;
    m[7:0]  = sel[0] ? new_v[7:0]  : old_v[7:0];
    m[15:8] = sel[1] ? new_v[15:8] : old_v[15:8];
    merge16 = CNT_W'(m);
  endfunction

  // Request seen, and the acknowledged edge where a write lands
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire bus_wr  = bus_req & wb_we_i & ack_q;
  wire lane0   = wb_sel_i[0];

  // Write strobes
  wire wr_ctrl   = bus_wr & lane0 & hit(wb_adr_i, `FG_ADDR_CTRL);
  wire wr_satb   = bus_wr & hit(wb_adr_i, `FG_ADDR_SAT_BLANK);
  wire wr_ocpb   = bus_wr & hit(wb_adr_i, `FG_ADDR_OCP_BLANK);
  wire wr_clr    = bus_wr & lane0 & hit(wb_adr_i, `FG_ADDR_EVT_CLR);
  wire wr_en     = bus_wr & lane0 & hit(wb_adr_i, `FG_ADDR_EVT_EN);

  // Writing one to the reactivation bit is the fast reactivation
  wire reactivate = wr_ctrl & wb_dat_i[`FG_CTRL_REACT_BIT];

  // Control fields out to the logic
  wire clamp_en = ctrl_q[`FG_CTRL_CLAMP_BIT];
  wire sat_en   = ctrl_q[`FG_CTRL_SAT_EN_BIT];
  wire ocp_en   = ctrl_q[`FG_CTRL_OCP_EN_BIT];

  // Threshold select drives the analog reference mux
  assign saturation_threshold_select =
    ctrl_q[`FG_CTRL_THR_MSB:`FG_CTRL_THR_LSB];

  // Configuration registers; reactivation bit is not stored
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q                          <= `FG_CTRL_RST;
      saturation_blanking_time_reg_q  <= CNT_W'(`FG_SAT_BLANK_RST);
      overcurrent_blanking_time_reg_q <= CNT_W'(`FG_OCP_BLANK_RST);
      evt_en_q                        <= `FG_EVT_EN_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wb_dat_i[`FG_CTRL_MSB:0] & ~(6'h01 << `FG_CTRL_REACT_BIT);
      end
      if (wr_satb) begin
        saturation_blanking_time_reg_q <=
          merge16(saturation_blanking_time_reg_q, wb_dat_i, wb_sel_i);
      end
      if (wr_ocpb) begin
        overcurrent_blanking_time_reg_q <=
          merge16(overcurrent_blanking_time_reg_q, wb_dat_i, wb_sel_i);
      end
      if (wr_en) begin
        evt_en_q <= wb_dat_i[`FG_EVT_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Turn-on and hard-off edges
  // ---------------------------------------------------------------

  // Previous PWM command to spot the turn-on start
  logic pwm_q;
  wire  turn_on = pwm_on_cmd & ~pwm_q;

  // PWM command history
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= pwm_on_cmd;
    end
  end

  // ---------------------------------------------------------------
  // Blanking counters
  // ---------------------------------------------------------------

  // Down counters, zero means no blanking
  logic [CNT_W-1:0] sat_cnt_q;
  logic [CNT_W-1:0] ocp_cnt_q;
  wire  sat_blank = (sat_cnt_q != '0);
  wire  ocp_blank = (ocp_cnt_q != '0);

  // Saturation counter reloads at turn-on and at hard-off start, overcurrent counter at turn-on only, then count down
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sat_cnt_q <= '0;
      ocp_cnt_q <= '0;
    end else begin
      if (turn_on || hard_off_start) begin
        sat_cnt_q <= saturation_blanking_time_reg_q;
      end else if (sat_blank) begin
        sat_cnt_q <= sat_cnt_q - CNT_W'(1);
      end
      if (turn_on) begin
        ocp_cnt_q <= overcurrent_blanking_time_reg_q;
      end else if (ocp_blank) begin
        ocp_cnt_q <= ocp_cnt_q - CNT_W'(1);
      end
    end
  end

  // Hard-off extension in progress; the counter is shared with
  // turn-on blanking, since the two phases never overlap
  logic off_ext_q;

  // Remember which phase the saturation counter is timing
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      off_ext_q <= 1'b0;
    end else if (hard_off_start) begin
      off_ext_q <= 1'b1;
    end else if (turn_on) begin
      off_ext_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Saturation sense pin control
  // ---------------------------------------------------------------

  // Turn-on cycle and its blanking hold the pin low; counter loads late
  wire on_pull  = pwm_on_cmd & (turn_on | (sat_blank & ~off_ext_q));
  // Plateau, hard-off start and its extension hold the pin, no gap
  wire off_pull = two_level_turnoff | hard_off_start |
                  (off_ext_q & sat_blank);

  assign saturation_sense_pulldown = on_pull | off_pull;
  // Clamp keeps the DC link from charging through the pull-up
  assign saturation_sense_clamp = clamp_en & ~pwm_on_cmd;

  // ---------------------------------------------------------------
  // Guard state and fault detection
  // ---------------------------------------------------------------

  fast_guard_pkg::guard_state_t state_q;
  fast_guard_pkg::guard_state_t state_d;
  wire running = (state_q == fast_guard_pkg::ST_RUN);

  // Monitoring windows; each gated by its own enable, the run state, the on command and its own blanking
  wire sat_mon = running & sat_en & pwm_on_cmd & ~turn_on &
                 ~sat_blank & ~two_level_turnoff;
  wire ocp_mon = running & ocp_en & pwm_on_cmd & ~turn_on &
                 ~ocp_blank;

  // Fault conditions
  wire sat_fault = sat_mon & sat_cmp;
  wire ocp_fault = ocp_mon & ocp1_cmp;
  wire chk_event = ocp_mon & ocp2_cmp;
  // Validity falling edge on the filtered level
  logic env_q;
  wire  en_fault = env_q & ~env_cmp;

  wire safe_fault = sat_fault | ocp_fault;
  wire any_fault  = safe_fault | en_fault;

  // Next guard state: a fault wins over a reactivation
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      fast_guard_pkg::ST_RUN: begin
        if (any_fault) begin
          state_d = fast_guard_pkg::ST_HALT;
        end
      end
      fast_guard_pkg::ST_HALT: begin
        if (reactivate && !any_fault) begin
          state_d = fast_guard_pkg::ST_RUN;
        end
      end
      default: begin
        state_d = fast_guard_pkg::ST_HALT;
      end
    endcase
  end

  // Guard state, turn-off pulses and validity history
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q             <= fast_guard_pkg::ST_RUN;
      env_q               <= 1'b0;
      safe_turnoff_req    <= 1'b0;
      regular_turnoff_req <= 1'b0;
    end else begin
      state_q             <= state_d;
      env_q               <= env_cmp;
      // Safe sequence for the current protections
      safe_turnoff_req    <= safe_fault;
      // Regular sequence for the enable loss only
      regular_turnoff_req <= en_fault & ~safe_fault;
    end
  end

  // Fault line low while the driver is disabled
  assign driver_disabled     = ~running;
  assign fast_fault_output_n = running;

  // ---------------------------------------------------------------
  // Sticky event flags and interrupt
  // ---------------------------------------------------------------

  // Hardware set per bit
  wire [`FG_EVT_W-1:0] evt_set = {chk_event, en_fault,
                                  ocp_fault, sat_fault};
  // Software clear per bit
  wire [`FG_EVT_W-1:0] evt_clr =
    wr_clr ? wb_dat_i[`FG_EVT_W-1:0] : '0;

  // Set wins over a clear in the same cycle
  always_comb begin
    evt_d = (evt_q & ~evt_clr) | evt_set;
  end

  // Sticky flags: saturation, overcurrent, enable, path check
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      evt_q <= '0;
    end else begin
      evt_q <= evt_d;
    end
  end

  assign irq = |(evt_q & evt_en_q);

  // ---------------------------------------------------------------
  // Live status and read mux
  // ---------------------------------------------------------------

  // Overcurrent comparators hidden while blanking runs
  wire ocp1_stat = ocp1_cmp & ~ocp_blank & ~turn_on;
  wire ocp2_stat = ocp2_cmp & ~ocp_blank & ~turn_on;

  // Live status word
  wire [31:0] live_w = 32'h0000_0000 |
    (32'(sat_cmp)   << `FG_LIVE_SAT_BIT) |
    (32'(ocp1_stat) << `FG_LIVE_OCP1_BIT) |
    (32'(ocp2_stat) << `FG_LIVE_OCP2_BIT) |
    (32'(env_cmp)   << `FG_LIVE_ENV_BIT) |
    (32'(~running)  << `FG_LIVE_HALT_BIT) |
    (32'(saturation_sense_pulldown) << `FG_LIVE_PULL_BIT);

  // Read selection; unmapped and write-only words read zero
  wire [31:0] rd_mux =
    hit(wb_adr_i, `FG_ADDR_CTRL)      ? 32'(ctrl_q) :
    hit(wb_adr_i, `FG_ADDR_SAT_BLANK) ?
      32'(saturation_blanking_time_reg_q) :
    hit(wb_adr_i, `FG_ADDR_OCP_BLANK) ?
      32'(overcurrent_blanking_time_reg_q) :
    hit(wb_adr_i, `FG_ADDR_LIVE)      ? live_w :
    hit(wb_adr_i, `FG_ADDR_EVT_STAT)  ? 32'(evt_q) :
    hit(wb_adr_i, `FG_ADDR_EVT_EN)    ? 32'(evt_en_q) :
    32'h0000_0000;

  // One wait state: ack and data rise together, one cycle after
  // the request; ack drops the cycle after, data holds
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= bus_req & ~ack_q;
      if (bus_req && !ack_q && !wb_we_i) begin
        rdat_q <= rd_mux;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

endmodule // fast_guard

`default_nettype wire

// File: sense_network_model.sv
// Behavioural model of the sense network and enable source at the guard
`timescale 1ns/100ps
`default_nettype none
module sense_network_model (
  input  wire logic saturation_sense_pulldown, // Pin held low by guard
  input  wire logic saturation_sense_clamp,    // Pin tied to ground
  input  wire logic sat_over,                  // Collector voltage high
  input  wire logic ocp_over,                  // Shunt over shutdown level
  input  wire logic chk_over,                  // Shunt over check level
  input  wire logic en_ok,                     // Host enable valid
  output logic      saturation_comp_raw,
  output logic      overcurrent_shutdown_raw,
  output logic      overcurrent_check_raw,
  output logic      external_enable_valid_raw
);
  // A pin held low reads under the reference whatever the collector does
  assign saturation_comp_raw = sat_over && !saturation_sense_pulldown
                               && !saturation_sense_clamp;
  // Shunt path is never pulled, so both levels show as driven
  assign overcurrent_shutdown_raw  = ocp_over;
  assign overcurrent_check_raw     = chk_over || ocp_over;
  assign external_enable_valid_raw = en_ok;
endmodule // sense_network_model
`default_nettype wire

// File: fast_guard_props.sv
// Concurrent checks on the fast guard ports
`timescale 1ns/100ps
`default_nettype none
`include "fast_guard_params.svh"
module fast_guard_props (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        pwm_on_cmd,
  input wire logic        two_level_turnoff,
  input wire logic        saturation_sense_pulldown,
  input wire logic        saturation_sense_clamp,
  input wire logic [1:0]  saturation_threshold_select,
  input wire logic        safe_turnoff_req,
  input wire logic        regular_turnoff_req,
  input wire logic        driver_disabled,
  input wire logic        fast_fault_output_n
);
  // Control write on its acknowledging edge
  wire ctrl_wr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
                  && wb_adr_i == `FG_ADDR_CTRL;
  wire react_wr = ctrl_wr && wb_dat_i[`FG_CTRL_REACT_BIT];
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Turn-on seen over two cycles
  sequence s_turn_on;
    !pwm_on_cmd ##1 pwm_on_cmd;
  endsequence
  // Request waiting for its answer
  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  a_turnon_pulldown: assert property (
    s_turn_on |-> saturation_sense_pulldown)
    else $error("pin not held low at turn-on");
  a_plateau_pulldown: assert property (
    two_level_turnoff |-> saturation_sense_pulldown)
    else $error("pin not held low on plateau");
  a_clamp_on_off: assert property (
    pwm_on_cmd |-> !saturation_sense_clamp)
    else $error("clamp active while on");
  a_clamp_cause: assert property (
    !$stable(saturation_sense_clamp)
    |-> !$stable(pwm_on_cmd) || $past(ctrl_wr))
    else $error("clamp moved without cause");
  a_thr_cause: assert property (
    !$stable(saturation_threshold_select) |-> $past(ctrl_wr))
    else $error("threshold moved without write");
  a_safe_fault: assert property (
    safe_turnoff_req |-> !fast_fault_output_n)
    else $error("safe turn-off without fault line");
  a_safe_pulse: assert property (
    safe_turnoff_req |=> !safe_turnoff_req)
    else $error("safe turn-off longer than a cycle");
  a_regular_only: assert property (
    regular_turnoff_req |-> !safe_turnoff_req && !fast_fault_output_n)
    else $error("regular turn-off misplaced");
  a_fault_holds: assert property (
    !fast_fault_output_n && !react_wr && !$past(react_wr)
    |=> !fast_fault_output_n)
    else $error("fault line released without reactivation");
  a_disable_fault: assert property (
    $rose(driver_disabled) |-> ##[0:1] !fast_fault_output_n)
    else $error("disable without fault line");
  a_ack_answer: assert property (s_bus_req |=> wb_ack_o)
    else $error("bus answer late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than a cycle");
endmodule // fast_guard_props
bind fast_guard fast_guard_props u_fast_guard_props (
  .clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .pwm_on_cmd(pwm_on_cmd),
  .two_level_turnoff(two_level_turnoff),
  .saturation_sense_pulldown(saturation_sense_pulldown),
  .saturation_sense_clamp(saturation_sense_clamp),
  .saturation_threshold_select(saturation_threshold_select),
  .safe_turnoff_req(safe_turnoff_req),
  .regular_turnoff_req(regular_turnoff_req),
  .driver_disabled(driver_disabled),
  .fast_fault_output_n(fast_fault_output_n));
`default_nettype wire

// File: fast_guard_bench.sv
// Self-checking bench for the fast guard block
`timescale 1ns/100ps
`default_nettype none
`include "fast_guard_params.svh"
module fast_guard_bench;
  logic        clock, rst_n;                  // Clock and reset
  logic        wb_cyc_i, wb_stb_i, wb_we_i;   // Bus request
  logic [7:0]  wb_adr_i;                      // Byte address
  logic [3:0]  wb_sel_i;                      // Byte lanes
  logic [31:0] wb_dat_i, wb_dat_o, rd;        // Bus data, last read
  logic        wb_ack_o, pwm_on_cmd, tlt, hard_off;
  logic        sat_over, ocp_over, chk_over, en_ok; // Far-side levels
  logic        sat_raw, ocp_raw, chk_raw, env_raw;  // Comparator lines
  logic        pull, clamp, safe_req, reg_req, dis, fault_n, irq;
  logic [1:0]  thr;                           // Threshold select
  int          err_total, check_count, cyc_cnt;

  fast_guard u_fast_guard (.clock(clock), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pwm_on_cmd(pwm_on_cmd),
    .two_level_turnoff(tlt), .hard_off_start(hard_off),
    .saturation_comp_raw(sat_raw), .overcurrent_shutdown_raw(ocp_raw),
    .overcurrent_check_raw(chk_raw), .external_enable_valid_raw(env_raw),
    .saturation_sense_pulldown(pull), .saturation_sense_clamp(clamp),
    .saturation_threshold_select(thr), .safe_turnoff_req(safe_req),
    .regular_turnoff_req(reg_req), .driver_disabled(dis),
    .fast_fault_output_n(fault_n), .irq(irq));
  sense_network_model u_sense_network_model (
    .saturation_sense_pulldown(pull), .saturation_sense_clamp(clamp),
    .sat_over(sat_over), .ocp_over(ocp_over), .chk_over(chk_over),
    .en_ok(en_ok), .saturation_comp_raw(sat_raw),
    .overcurrent_shutdown_raw(ocp_raw), .overcurrent_check_raw(chk_raw),
    .external_enable_valid_raw(env_raw));

  // 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Hang guard, far above the expected run length
  always @(posedge clock) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 3000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // One classic cycle; holds everything until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    // Only the hang guard ends this wait
    do begin
      @(posedge clock);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // Bounded wait for the fault line
  task automatic wait_fault();
    int n;
    n = 0;
    while (fault_n !== 1'b0 && n < 40) begin
      @(posedge clock);
      n++;
    end
    chk("fault_line", 32'h0, 32'(fault_n));
  endtask
  // Clear events and bring the guard back
  task automatic reactivate();
    wb(1'b1, `FG_ADDR_EVT_CLR, 32'hF);
    wb(1'b1, `FG_ADDR_CTRL, 32'h38);
    tick(2);
    chk("released", 32'h1, 32'(fault_n));
  endtask
  task automatic t_regs();
    wb(1'b0, `FG_ADDR_CTRL, 32'h0);
    chk("ctrl_rst", 32'(`FG_CTRL_RST), rd);
    wb(1'b0, `FG_ADDR_SAT_BLANK, 32'h0);
    chk("sat_blank_rst", 32'(`FG_SAT_BLANK_RST), rd);
    wb(1'b0, `FG_ADDR_OCP_BLANK, 32'h0);
    chk("ocp_blank_rst", 32'(`FG_OCP_BLANK_RST), rd);
    wb(1'b0, 8'h1C, 32'h0);
    chk("unmapped", 32'h0, rd);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, `FG_ADDR_CTRL, 32'h30 | (i << 1));
      tick(1);
      chk("thr_sel", 32'(i), 32'(thr));
    end
    wb(1'b1, `FG_ADDR_CTRL, 32'h30);
    wb(1'b1, `FG_ADDR_SAT_BLANK, 32'h4);
    wb(1'b1, `FG_ADDR_EVT_EN, 32'hF);
    wb(1'b0, `FG_ADDR_EVT_EN, 32'h0);
    chk("evt_en", 32'hF, rd);
    $display("t_regs done");
  endtask
  task automatic t_sat();
    @(posedge clock);
    pwm_on_cmd <= 1'b1; // On-time kept well above blanking
    sat_over   <= 1'b1;
    tick(2);
    chk("blank_pull", 32'h1, 32'(pull));
    chk("blank_quiet", 32'h1, 32'(fault_n));
    wait_fault();
    chk("safe_req", 32'h1, 32'(safe_req));
    chk("disabled", 32'h1, 32'(dis));
    wb(1'b0, `FG_ADDR_EVT_STAT, 32'h0);
    chk("sat_flag", 32'h1, rd & 32'hF);
    chk("irq_on", 32'h1, 32'(irq));
    pwm_on_cmd <= 1'b0;
    sat_over   <= 1'b0;
    tick(6);
    chk("held", 32'h0, 32'(fault_n));
    reactivate();
    $display("t_sat done");
  endtask
  task automatic t_off();
    sat_over <= 1'b1;
    ocp_over <= 1'b1;
    tick(12);
    chk("off_quiet", 32'h1, 32'(fault_n));
    wb(1'b0, `FG_ADDR_LIVE, 32'h0);
    chk("sat_live", 32'h1, 32'(rd[`FG_LIVE_SAT_BIT]));
    wb(1'b1, `FG_ADDR_CTRL, 32'h31);
    tick(1);
    chk("clamp", 32'h1, 32'(clamp));
    wb(1'b1, `FG_ADDR_CTRL, 32'h30);
    sat_over <= 1'b0;
    ocp_over <= 1'b0;
    $display("t_off done");
  endtask
  task automatic t_ocp();
    wb(1'b1, `FG_ADDR_OCP_BLANK, 32'h14);
    chk_over   <= 1'b1;
    pwm_on_cmd <= 1'b1;
    tick(8); // Check level settled, blanking still running
    wb(1'b0, `FG_ADDR_LIVE, 32'h0);
    chk("ocp_masked", 32'h0, rd & 32'h6);
    tick(30);
    wb(1'b0, `FG_ADDR_LIVE, 32'h0);
    chk("chk_live", 32'h4, rd & 32'h6);
    chk("chk_no_stop", 32'h1, 32'(fault_n));
    ocp_over <= 1'b1;
    wait_fault();
    chk("ocp_safe_req", 32'h1, 32'(safe_req));
    wb(1'b0, `FG_ADDR_EVT_STAT, 32'h0);
    chk("ocp_flags", 32'hA, rd & 32'hF);
    pwm_on_cmd <= 1'b0;
    ocp_over   <= 1'b0;
    chk_over   <= 1'b0;
    reactivate();
    $display("t_ocp done");
  endtask
  task automatic t_en();
    wb(1'b0, `FG_ADDR_LIVE, 32'h0);
    chk("en_valid", 32'h1, 32'(rd[`FG_LIVE_ENV_BIT]));
    en_ok <= 1'b0;
    wait_fault();
    chk("reg_req", 32'h1, 32'(reg_req));
    chk("en_no_safe", 32'h0, 32'(safe_req));
    wb(1'b0, `FG_ADDR_EVT_STAT, 32'h0);
    chk("en_flag", 32'h4, rd & 32'hF);
    wb(1'b0, `FG_ADDR_LIVE, 32'h0);
    chk("en_invalid", 32'h0, 32'(rd[`FG_LIVE_ENV_BIT]));
    wb(1'b1, `FG_ADDR_EVT_EN, 32'h0);
    tick(1);
    chk("irq_masked", 32'h0, 32'(irq));
    wb(1'b1, `FG_ADDR_EVT_EN, 32'hF);
    en_ok <= 1'b1;
    tick(8);
    reactivate();
    chk("irq_cleared", 32'h0, 32'(irq));
    $display("t_en done");
  endtask
  task automatic t_hard();
    @(posedge clock);
    tlt <= 1'b1;
    tick(2);
    chk("plateau_pull", 32'h1, 32'(pull));
    tlt      <= 1'b0;
    hard_off <= 1'b1;
    @(posedge clock);
    hard_off <= 1'b0;
    chk("handover_pull", 32'h1, 32'(pull));
    tick(2);
    chk("extend_pull", 32'h1, 32'(pull));
    tick(8);
    chk("pull_done", 32'h0, 32'(pull));
    $display("t_hard done");
  endtask

  // Main sequence
  initial begin
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, pwm_on_cmd, tlt, hard_off} = '0;
    {sat_over, ocp_over, chk_over, en_ok} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {err_total, check_count, cyc_cnt} = '0;
    wb_sel_i = 4'hF;
    tick(2);
    rst_n <= 1'b1;
    en_ok <= 1'b1;
    tick(8);
    t_regs();
    t_sat();
    t_off();
    t_ocp();
    t_en();
    t_hard();
    complete_run();
  end
endmodule // fast_guard_bench
`default_nettype wire
